// file: rtl/ssp_defs.svh
// constants of the sensor serial slave port: offsets, fields, resets, timing
// assumes the includer uses these as plain macros
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define SSP_ADDR_W 6
`define SSP_FMT_ADDR 6'h31
`define SSP_FMT_WIRE_BIT 6
`define SSP_FMT_RST 8'h00
`define SSP_BYTE_LAST 3'h7
`define SSP_CMD_RW_BIT 7
`define SSP_CMD_BURST_BIT 6
`define SSP_CLK_NS 10
`define SSP_SCLK_MIN_NS 200
`define SSP_SCLK_MIN_CYC ((`SSP_SCLK_MIN_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_RD_OE_MAX_CYC 40

`endif

// file: rtl/ssp_pkg.sv
// types of the sensor serial slave port
// assumes nothing beyond the defs header
package ssp_pkg;

  typedef enum logic [1:0] {
    SSP_ST_IDLE = 2'b00,
    SSP_ST_CMD = 2'b01,
    SSP_ST_DATA = 2'b10,
    SSP_ST_DONE = 2'b11
  } ssp_state_t;

endpackage : ssp_pkg

// file: rtl/ssp_sync.sv
// two-flop synchroniser bank for the serial pins
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

module ssp_sync #(
  parameter int W = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output var logic [W-1:0] dout
);

  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // idle level of every serial pin is high
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          meta_r[i] <= 1'b1;
          dout[i] <= 1'b1;
        end
        else
        begin
          meta_r[i] <= din[i];
          dout[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : ssp_sync

`default_nettype wire

// file: rtl/ssp_top.sv
// sensor serial slave port: spi slave with register file and burst pointer
// assumes cs_n, sclk and sdi come from an external master, asynchronous to clk_sys
//
// What this block does
// - acts only as slave; chip select high means i2c mode, not spi.
// - bit 6 of format register 0x31 picks 4-wire when 0, 3-wire when 1.
// - clock polarity 1 and phase 1; serial clock idles high.
// - data changes on falling clock edge, is sampled on rising edge.
// - first byte holds read flag then burst flag; burst flag allows many bytes.
// - in a burst, pointer steps by one after every further eight clocks.
// - pointer keeps stepping until clocks stop and chip select rises.
// - data output driven only for read data, released after chip select rises.
// - with chip select high, a valid i2c start is only flagged on i2c_start_r; no i2c access follows.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"

module ssp_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output var logic sdo_o,
  output var logic sdo_oe,
  output var logic sdio_o,
  output var logic sdio_oe,
  output var logic [7:0] fmt_cfg_r,
  output var logic i2c_mode_r,
  output var logic i2c_start_r
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge detection

  logic s_cs_n;
  logic s_sclk;
  logic s_sdi;
  logic sclk_d_r;
  logic sdi_d_r;
  logic rise;
  logic fall;

  ssp_sync #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({cs_n, sclk, sdi}),
    .dout({s_cs_n, s_sclk, s_sdi})
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sclk_d_r <= 1'b1;
      sdi_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= s_sclk;
      sdi_d_r <= s_sdi;
    end
  end

  // edges only count inside a frame
  assign rise = s_sclk && !sclk_d_r && !s_cs_n;
  assign fall = !s_sclk && sclk_d_r && !s_cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencing

  ssp_pkg::ssp_state_t st_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] rx_byte;
  logic byte_end;
  logic rw_r;
  logic burst_increment_flag;
  logic [`SSP_ADDR_W-1:0] ptr_r;

  assign rx_byte = {rx_sh_r, s_sdi};
  assign byte_end = rise && (bit_cnt_r == `SSP_BYTE_LAST);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ssp_pkg::SSP_ST_IDLE;
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
      rw_r <= 1'b0;
      burst_increment_flag <= 1'b0;
      ptr_r <= '0;
    end
    else if (s_cs_n)
    begin
      st_r <= ssp_pkg::SSP_ST_IDLE;
      bit_cnt_r <= 3'h0;
    end
    else
    begin
      if (st_r == ssp_pkg::SSP_ST_IDLE)
        st_r <= ssp_pkg::SSP_ST_CMD;
      if (rise)
      begin
        rx_sh_r <= rx_byte[6:0];
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (byte_end && st_r == ssp_pkg::SSP_ST_CMD)
      begin
        rw_r <= rx_byte[`SSP_CMD_RW_BIT];
        burst_increment_flag <= rx_byte[`SSP_CMD_BURST_BIT];
        ptr_r <= rx_byte[`SSP_ADDR_W-1:0];
        st_r <= ssp_pkg::SSP_ST_DATA;
      end
      else if (byte_end && st_r == ssp_pkg::SSP_ST_DATA)
      begin
        if (burst_increment_flag)
          ptr_r <= ptr_r + 6'h01;
        else
          st_r <= ssp_pkg::SSP_ST_DONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file; the format register lives in its own flop

  logic [7:0] regs_r [0:(1<<`SSP_ADDR_W)-1];
  logic wr_en;

  function automatic logic [7:0] rd_reg(input logic [`SSP_ADDR_W-1:0] a);
    rd_reg = (a == `SSP_FMT_ADDR) ? fmt_cfg_r : regs_r[a];
  endfunction : rd_reg

  assign wr_en = byte_end && st_r == ssp_pkg::SSP_ST_DATA && !rw_r;

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
      regs_r[ptr_r] <= rx_byte;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fmt_cfg_r <= `SSP_FMT_RST;
    else if (wr_en && ptr_r == `SSP_FMT_ADDR)
      fmt_cfg_r <= rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data path; output changes only on falling edges

  logic [7:0] tx_sh_r;
  logic out_r;
  logic oe_r;
  logic three_wire;

  assign three_wire = fmt_cfg_r[`SSP_FMT_WIRE_BIT];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_sh_r <= 8'h00;
      out_r <= 1'b1;
      oe_r <= 1'b0;
    end
    else if (s_cs_n)
      oe_r <= 1'b0;
    else if (byte_end && st_r == ssp_pkg::SSP_ST_CMD && rx_byte[`SSP_CMD_RW_BIT])
      tx_sh_r <= rd_reg(rx_byte[`SSP_ADDR_W-1:0]);
    else if (byte_end && st_r == ssp_pkg::SSP_ST_DATA && rw_r && burst_increment_flag)
      tx_sh_r <= rd_reg(ptr_r + 6'h01);
    else if (fall)
    begin
      // writes never drive the line, so nothing returned then needs ignoring
      if (st_r == ssp_pkg::SSP_ST_DATA && rw_r)
      begin
        out_r <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        oe_r <= 1'b1;
      end
      else
        oe_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sdo_o <= 1'b1;
      sdio_o <= 1'b1;
      sdo_oe <= 1'b0;
      sdio_oe <= 1'b0;
    end
    else
    begin
      sdo_o <= out_r;
      sdio_o <= out_r;
      sdo_oe <= oe_r && !three_wire && !s_cs_n;
      sdio_oe <= oe_r && three_wire && !s_cs_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i2c mode detection; only the start condition is recognised here

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      i2c_mode_r <= 1'b1;
      i2c_start_r <= 1'b0;
    end
    else
    begin
      i2c_mode_r <= s_cs_n;
      i2c_start_r <= s_cs_n && s_sclk && sclk_d_r && sdi_d_r && !s_sdi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  localparam int rd_oe_max_cyc = `SSP_RD_OE_MAX_CYC;

  sequence rd_cmd_seen;
    byte_end && st_r == ssp_pkg::SSP_ST_CMD && rx_byte[`SSP_CMD_RW_BIT];
  endsequence

  sequence rd_fall_seen;
    fall && st_r == ssp_pkg::SSP_ST_DATA;
  endsequence

  a_oe_after_cs: assert property ($past(s_cs_n) |-> !sdo_oe && !sdio_oe)
    else $error("data output driven outside a frame");
  a_wire_select: assert property ((sdio_oe |-> three_wire) and (sdo_oe |-> !three_wire))
    else $error("data driven on the wrong pin for the wire mode");
  a_cmd_decode: assert property (byte_end && st_r == ssp_pkg::SSP_ST_CMD |=>
      rw_r == $past(rx_byte[7]) && ptr_r == $past(rx_byte[5:0])
      && st_r == ssp_pkg::SSP_ST_DATA)
    else $error("command byte decoded wrongly");
  a_ptr_advance: assert property (byte_end && st_r == ssp_pkg::SSP_ST_DATA
      && burst_increment_flag |=> ptr_r == $past(ptr_r) + 6'h01)
    else $error("burst pointer did not step by one");
  a_single_stop: assert property (byte_end && st_r == ssp_pkg::SSP_ST_DATA
      && !burst_increment_flag |=> st_r == ssp_pkg::SSP_ST_DONE)
    else $error("single transfer did not stop after one byte");
  a_cs_ends: assert property (s_cs_n |=> st_r == ssp_pkg::SSP_ST_IDLE)
    else $error("frame not ended by chip select");
  a_out_on_fall: assert property ($changed(out_r) |-> $past(fall))
    else $error("output changed away from a falling edge");
  a_sample_rise: assert property ($changed(bit_cnt_r) && !$past(s_cs_n) |-> $past(rise))
    else $error("input sampled away from a rising edge");
  a_i2c_start: assert property (s_cs_n && s_sclk && sclk_d_r && sdi_d_r && !s_sdi
      |=> i2c_start_r && i2c_mode_r)
    else $error("i2c start not flagged");
  a_read_drive: assert property (rd_cmd_seen ##[1:rd_oe_max_cyc] rd_fall_seen
      |=> oe_r || s_cs_n)
    else $error("read data not driven after falling edge");

endmodule : ssp_top

`default_nettype wire

// file: bench/ssp_master_model.sv
// spi bus master model for the slave port: frames, bytes, an i2c-style start
// assumes the bench calls its tasks and that clk_sys only paces the serial clock
`timescale 1ns/1ps
`default_nettype none
module ssp_master_model (
  input wire logic clk_sys,
  input wire logic wire3,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  output var logic cs_n,
  output var logic sclk,
  output var logic sdi
);
  logic m_d = 1'b1;
  logic m_oe = 1'b1;
  logic pat = 1'b0;
  logic oe_seen = 1'b0;
  logic cs_r = 1'b1;
  logic sclk_r = 1'b1;
  // a released line shows the inverse of its last level, never a stale copy
  always_comb sdi = sdio_oe ? sdio_o : (m_oe ? m_d : ~m_d);
  always_comb cs_n = cs_r;
  always_comb sclk = sclk_r;
  always @(negedge clk_sys) pat <= ~pat;
  always @(negedge clk_sys) if (sdo_oe || sdio_oe) oe_seen <= 1'b1;
  // 160 ns link clock sits above the 5 MHz ceiling on purpose, to show margin
  // no output data rate is set here, so rate against link speed never binds
  task automatic half();
    repeat (8) @(negedge clk_sys);
  endtask : half
  task automatic xbyte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_r = 1'b0;
      m_d = tx[i];
      m_oe = drv;
      half();
      rx[i] = wire3 ? sdi : (sdo_oe ? sdo_o : pat);
      sclk_r = 1'b1;
      half();
    end
  endtask : xbyte
  task automatic cs(input logic v);
    half();
    m_oe = 1'b1;  // lines always driven between frames
    m_d = 1'b1;
    cs_r = v;
    half();
  endtask : cs
  task automatic i2c_start();
    m_d = 1'b0;  // data falls while clock and select stay high
    half();
    m_d = 1'b1;
  endtask : i2c_start
endmodule : ssp_master_model
`default_nettype wire

// file: bench/tb.sv
// self-checking bench of the sensor serial slave port
// assumes the master model paces serial traffic at a 160 ns clock
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic w3 = 1'b0;
  logic cs_n, sclk, sdi, sdo_o, sdo_oe, sdio_o, sdio_oe, i2c_mode_r, i2c_start_r;
  logic [7:0] fmt_cfg_r;
  logic [7:0] rx;
  logic [7:0] mem [64];
  logic [7:0] wbuf [64];
  logic [5:0] a;
  int n_errors = 0;
  int samples_checked = 0;
  int n_start = 0;
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (i2c_start_r === 1'b1) n_start++;
  ssp_top dut_u (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .fmt_cfg_r(fmt_cfg_r), .i2c_mode_r(i2c_mode_r), .i2c_start_r(i2c_start_r));
  ssp_master_model m_u (.clk_sys(clk_sys), .wire3(w3), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_flag
  task automatic wrap_up();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // pointer after k data bytes; wraps inside the six-bit space
  function automatic logic [5:0] exp_ptr(input logic [5:0] ad, input int k);
    exp_ptr = ad + 6'(k);
  endfunction : exp_ptr
  function automatic logic [7:0] exp_rd(input logic [5:0] p);
    exp_rd = mem[p];
  endfunction : exp_rd
  // non-burst transfers only touch the first data byte
  task automatic xfer(input logic rd, input logic bst, input logic [5:0] ad, input int n);
    logic [5:0] p;
    m_u.oe_seen = 1'b0;
    m_u.cs(1'b0);
    chk_flag(i2c_mode_r, 1'b0);
    m_u.xbyte({rd, bst, ad}, 1'b1, rx);
    for (int k = 0; k < n; k++)
    begin
      p = exp_ptr(ad, k);
      m_u.xbyte(wbuf[k], !(rd && w3), rx);
      if (rd && (bst || k == 0)) chk_byte(rx, exp_rd(p));
      if (!rd && (bst || k == 0)) mem[p] = wbuf[k];
      if (!rd && (bst || k == 0) && p == `SSP_FMT_ADDR) w3 = wbuf[k][`SSP_FMT_WIRE_BIT];
    end
    m_u.cs(1'b1);
    if (!rd) chk_flag(m_u.oe_seen, 1'b0);
    if (rd) chk_flag(m_u.oe_seen, 1'b1);
    chk_flag(sdo_oe | sdio_oe, 1'b0);
    chk_flag(i2c_mode_r, 1'b1);
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1ms;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(8319));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    chk_byte(fmt_cfg_r, `SSP_FMT_RST);
    chk_flag(i2c_mode_r, 1'b1);
    chk_flag(sdo_oe | sdio_oe, 1'b0);
    $display("test reset done");
    repeat (4) @(negedge clk_sys);
    for (int k = 0; k < 64; k++) wbuf[k] = 8'($urandom);
    // keep 4-wire mode through the wrapping burst
    wbuf[6'(`SSP_FMT_ADDR - 6'h3E)][`SSP_FMT_WIRE_BIT] = 1'b0;
    xfer(1'b0, 1'b1, 6'h3E, 64);
    chk_byte(fmt_cfg_r, mem[`SSP_FMT_ADDR]);
    xfer(1'b1, 1'b1, 6'h3E, 64);
    $display("test burst done");
    repeat (6)
    begin
      a = 6'($urandom);
      if (a == `SSP_FMT_ADDR) a = a ^ 6'h01;
      wbuf[0] = 8'($urandom);
      wbuf[1] = 8'($urandom);
      xfer(1'b0, 1'b0, a, 2);
      xfer(1'b1, 1'b0, a, 1);
      xfer(1'b1, 1'b1, a, 2);
    end
    $display("test single done");
    wbuf[0] = 8'($urandom) | 8'h40;
    xfer(1'b0, 1'b0, `SSP_FMT_ADDR, 1);
    chk_byte(fmt_cfg_r, mem[`SSP_FMT_ADDR]);
    wbuf[0] = 8'($urandom);
    xfer(1'b0, 1'b0, 6'h05, 1);
    xfer(1'b1, 1'b1, 6'h03, 4);
    wbuf[0] = 8'h00;
    xfer(1'b0, 1'b0, `SSP_FMT_ADDR, 1);
    chk_byte(fmt_cfg_r, 8'h00);
    xfer(1'b1, 1'b1, 6'h04, 2);
    $display("test wire mode done");
    chk_byte(8'(n_start), 8'h00);
    m_u.i2c_start();
    repeat (8) @(negedge clk_sys);
    chk_byte(8'(n_start), 8'h01);
    $display("test i2c start done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
